// [design/smmrc_ctrl.sv]
// smm memory range control: configuration register, lock and routing
`timescale 1ns/1ps
`include "smmrc_map.svh"

// ----------------------------------------------------------------------
// ----------------------------------------------------------------------

module smmrc_ctrl (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// configuration space access
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	// memory request from the processor side
	input wire logic [31:0] i_tom,
	input wire smmrc_pkg::smmrc_req_t i_req,
	output smmrc_pkg::smmrc_resp_t o_resp,
	// status toward the rest of the bridge
	output logic o_gfx_enable,
	output logic o_gfx_clk_en,
	output logic o_dram_param_lock,
	output logic o_violation,
	output logic [31:0] o_top_secure_segment_base,
	output logic [31:0] o_gfx_base,
	output logic [31:0] o_sysram_top
);
	import smmrc_pkg::*;

	smmrc_state_t state;
	smmrc_state_t next_state;
	smmrc_resp_t route;
	logic hit_ctrl;
	logic wr_ctrl;
	logic rd_ctrl;
	logic locked;
	logic [31:0] top_secure_segment_size;
	logic [31:0] gfx_size;
	logic [31:0] top_secure_segment_base;
	logic [31:0] gfx_base;

	// ------------------------------------------------------------------
	// routing decision
	// ------------------------------------------------------------------
	smmrc_route u_route (
		.i_ctrl(state.ctrl),
		.i_map(state.map),
		.i_tom(i_tom),
		.i_req(i_req),
		.o_resp(route)
	);

	// ------------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------------
	always_comb begin
		hit_ctrl = i_cfg_addr == `SMMRC_CTRL_OFFSET;
		wr_ctrl = i_cfg_wr && hit_ctrl;
		rd_ctrl = i_cfg_rd && hit_ctrl;
		locked = state.ctrl.secure_space_lock;
	end

	// ------------------------------------------------------------------
	// sizes of the taken blocks
	// ------------------------------------------------------------------
	always_comb begin
		case (state.ctrl.upper_secure_range_select)
			`SMMRC_UPPER_SECURE_RANGE_SELECT_512K: begin
				top_secure_segment_size = `SMMRC_SIZE_512K;
			end
			`SMMRC_UPPER_SECURE_RANGE_SELECT_1M: begin
				top_secure_segment_size = `SMMRC_SIZE_1M;
			end
			default: begin
				top_secure_segment_size = `SMMRC_SIZE_0;
			end
		endcase
	end

	always_comb begin
		case (state.ctrl.graphics_memory_size_select)
			`SMMRC_GMS_512K: begin
				gfx_size = `SMMRC_SIZE_512K;
			end
			`SMMRC_GMS_1M: begin
				gfx_size = `SMMRC_SIZE_1M;
			end
			default: begin
				gfx_size = `SMMRC_SIZE_0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// carving: top segment first, graphics just below
	// ------------------------------------------------------------------
	always_comb begin
		top_secure_segment_base = i_tom - top_secure_segment_size;
		gfx_base = top_secure_segment_base - gfx_size;
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;

		// graphics size field
		if (wr_ctrl && !locked) begin
			next_state.ctrl.graphics_memory_size_select =
				i_cfg_wdata[`SMMRC_GMS_MSB:`SMMRC_GMS_LSB];
		end

		// upper secure range field
		if (wr_ctrl && !locked) begin
			next_state.ctrl.upper_secure_range_select =
				i_cfg_wdata[`SMMRC_UPPER_SECURE_RANGE_SELECT_MSB:`SMMRC_UPPER_SECURE_RANGE_SELECT_LSB];
		end

		// lower secure range field, msb
		if (wr_ctrl && !locked) begin
			next_state.ctrl.lower_secure_range_select[1] =
				i_cfg_wdata[`SMMRC_LOWER_SECURE_RANGE_SELECT_MSB];
		end

		// lower secure range field, lsb
		if (wr_ctrl) begin
			if (!locked) begin
				next_state.ctrl.lower_secure_range_select[0] =
					i_cfg_wdata[`SMMRC_LOWER_SECURE_RANGE_SELECT_LSB];
			end else if (state.ctrl.lower_secure_range_select[1]) begin
				next_state.ctrl.lower_secure_range_select[0] =
					i_cfg_wdata[`SMMRC_LOWER_SECURE_RANGE_SELECT_LSB];
			end
		end

		// lock: sets by write, never clears by write
		if (wr_ctrl && !locked && i_cfg_wdata[`SMMRC_LOCK_BIT]) begin
			next_state.ctrl.secure_space_lock = 1'b1;
		end

		// violation flag: write one clears, a new hit wins
		if (wr_ctrl && i_cfg_wdata[`SMMRC_ERR_BIT]) begin
			next_state.ctrl.extended_secure_violation_flag = 1'b0;
		end
		if (route.violation) begin
			next_state.ctrl.extended_secure_violation_flag = 1'b1;
		end

		// read data, zero when not addressed
		if (rd_ctrl) begin
			next_state.rdata = state.ctrl;
		end else begin
			next_state.rdata = 8'h00;
		end

		// registered routing answer
		next_state.resp = route;
		if (!i_req.valid) begin
			next_state.resp.violation = 1'b0;
		end

		// taken-memory map
		next_state.map.top_secure_segment_base = top_secure_segment_base;
		next_state.map.gfx_base = gfx_base;
		next_state.map.top_secure_segment_en =
			state.ctrl.upper_secure_range_select[1];
		next_state.map.high_secure_remap_en =
			(state.ctrl.upper_secure_range_select != `SMMRC_UPPER_SECURE_RANGE_SELECT_OFF) &&
			(state.ctrl.lower_secure_range_select == `SMMRC_LOWER_SECURE_RANGE_SELECT_OFF);
		next_state.map.gfx_en =
			state.ctrl.graphics_memory_size_select[1];

		// graphics clock gate
		next_state.gfx_clk_en =
			state.ctrl.graphics_memory_size_select != `SMMRC_GMS_OFF;
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state.ctrl <= `SMMRC_CTRL_RESET;
			state.rdata <= 8'h00;
			state.resp.valid <= 1'b0;
			state.resp.dest <= SMMRC_TO_HUB;
			state.resp.addr <= 32'h0000_0000;
			state.resp.violation <= 1'b0;
			state.map.top_secure_segment_base <= 32'h0000_0000;
			state.map.gfx_base <= 32'h0000_0000;
			state.map.top_secure_segment_en <= 1'b0;
			state.map.high_secure_remap_en <= 1'b0;
			state.map.gfx_en <= 1'b0;
			state.gfx_clk_en <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	always_comb begin
		o_cfg_rdata = state.rdata;
		o_resp = state.resp;
		o_gfx_enable = state.gfx_clk_en;
		o_gfx_clk_en = state.gfx_clk_en;
		o_dram_param_lock = state.ctrl.secure_space_lock;
		o_violation = state.ctrl.extended_secure_violation_flag;
		o_top_secure_segment_base = state.map.top_secure_segment_base;
		o_gfx_base = state.map.gfx_base;
		o_sysram_top = state.map.gfx_base;
	end

endmodule

// [design/smmrc_map.svh]
// address map, field positions, reset values and codes for smm range control
`ifndef SMMRC_MAP_SVH
`define SMMRC_MAP_SVH

// ----------------------------------------------------------------------
// configuration register
// ----------------------------------------------------------------------
`define SMMRC_CTRL_OFFSET 8'h70
`define SMMRC_CTRL_RESET 8'h00
`define SMMRC_GMS_MSB 7
`define SMMRC_GMS_LSB 6
`define SMMRC_UPPER_SECURE_RANGE_SELECT_MSB 5
`define SMMRC_UPPER_SECURE_RANGE_SELECT_LSB 4
`define SMMRC_LOWER_SECURE_RANGE_SELECT_MSB 3
`define SMMRC_LOWER_SECURE_RANGE_SELECT_LSB 2
`define SMMRC_LOCK_BIT 1
`define SMMRC_ERR_BIT 0

// ----------------------------------------------------------------------
// field codes
// ----------------------------------------------------------------------
`define SMMRC_GMS_OFF 2'h0
`define SMMRC_GMS_NONE 2'h1
`define SMMRC_GMS_512K 2'h2
`define SMMRC_GMS_1M 2'h3
`define SMMRC_UPPER_SECURE_RANGE_SELECT_OFF 2'h0
`define SMMRC_UPPER_SECURE_RANGE_SELECT_HIGH_SECURE_REMAP 2'h1
`define SMMRC_UPPER_SECURE_RANGE_SELECT_512K 2'h2
`define SMMRC_UPPER_SECURE_RANGE_SELECT_1M 2'h3
`define SMMRC_LOWER_SECURE_RANGE_SELECT_OFF 2'h0
`define SMMRC_LOWER_SECURE_RANGE_SELECT_RAM 2'h1
`define SMMRC_LOWER_SECURE_RANGE_SELECT_CODE 2'h2
`define SMMRC_LOWER_SECURE_RANGE_SELECT_SMM 2'h3

// ----------------------------------------------------------------------
// sizes and address windows
// ----------------------------------------------------------------------
`define SMMRC_SIZE_0 32'h0000_0000
`define SMMRC_SIZE_512K 32'h0008_0000
`define SMMRC_SIZE_1M 32'h0010_0000
`define SMMRC_AB_BASE 32'h000A_0000
`define SMMRC_AB_LAST 32'h000B_FFFF
`define SMMRC_HIGH_SECURE_REMAP_BASE 32'hFEEA_0000
`define SMMRC_HIGH_SECURE_REMAP_LAST 32'hFEEB_FFFF
`define SMMRC_AB_OFS_MASK 32'h0001_FFFF

`endif

// [design/smmrc_pkg.sv]
// types shared by the smm range control block
package smmrc_pkg;

	// ------------------------------------------------------------------
	// routing destinations
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SMMRC_TO_DRAM = 2'h0,
		SMMRC_TO_GFX = 2'h1,
		SMMRC_TO_HUB = 2'h3
	} smmrc_dest_t;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] graphics_memory_size_select;
		logic [1:0] upper_secure_range_select;
		logic [1:0] lower_secure_range_select;
		logic secure_space_lock;
		logic extended_secure_violation_flag;
	} smmrc_ctrl_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic smm;
		logic code;
		logic write;
		logic writeback;
	} smmrc_req_t;

	typedef struct packed {
		logic valid;
		smmrc_dest_t dest;
		logic [31:0] addr;
		logic violation;
	} smmrc_resp_t;

	typedef struct packed {
		logic [31:0] top_secure_segment_base;
		logic [31:0] gfx_base;
		logic top_secure_segment_en;
		logic high_secure_remap_en;
		logic gfx_en;
	} smmrc_map_t;

	typedef struct packed {
		smmrc_ctrl_t ctrl;
		logic [7:0] rdata;
		smmrc_resp_t resp;
		smmrc_map_t map;
		logic gfx_clk_en;
	} smmrc_state_t;

endpackage

// [design/smmrc_route.sv]
// combinational routing of one processor memory request
`timescale 1ns/1ps
`include "smmrc_map.svh"

module smmrc_route (
	// programmed state
	input wire smmrc_pkg::smmrc_ctrl_t i_ctrl,
	input wire smmrc_pkg::smmrc_map_t i_map,
	input wire logic [31:0] i_tom,
	// request and decision
	input wire smmrc_pkg::smmrc_req_t i_req,
	output smmrc_pkg::smmrc_resp_t o_resp
);
	import smmrc_pkg::*;

	logic in_ab;
	logic in_high_secure_remap;
	logic in_top_secure_segment;
	logic in_gfx;
	logic in_ram;
	smmrc_dest_t vga_dest;

	// ------------------------------------------------------------------
	// window hits
	// ------------------------------------------------------------------
	always_comb begin
		in_ab = (i_req.addr >= `SMMRC_AB_BASE) &&
			(i_req.addr <= `SMMRC_AB_LAST);
		in_high_secure_remap = i_map.high_secure_remap_en && (i_req.addr >= `SMMRC_HIGH_SECURE_REMAP_BASE) &&
			(i_req.addr <= `SMMRC_HIGH_SECURE_REMAP_LAST);
		in_top_secure_segment = i_map.top_secure_segment_en && (i_req.addr >= i_map.top_secure_segment_base) &&
			(i_req.addr < i_tom);
		in_gfx = i_map.gfx_en && (i_req.addr >= i_map.gfx_base) &&
			(i_req.addr < i_map.top_secure_segment_base);
		in_ram = i_req.addr < i_map.gfx_base;
		vga_dest = (i_ctrl.graphics_memory_size_select == `SMMRC_GMS_OFF) ?
			SMMRC_TO_HUB : SMMRC_TO_GFX;
	end

	// ------------------------------------------------------------------
	// destination
	// ------------------------------------------------------------------
	always_comb begin
		o_resp.valid = i_req.valid;
		o_resp.addr = i_req.addr;
		o_resp.dest = SMMRC_TO_HUB;
		o_resp.violation = 1'b0;
		if (in_ab) begin
			case (i_ctrl.lower_secure_range_select)
				`SMMRC_LOWER_SECURE_RANGE_SELECT_RAM: begin
					o_resp.dest = SMMRC_TO_DRAM;
				end
				`SMMRC_LOWER_SECURE_RANGE_SELECT_CODE: begin
					o_resp.dest = (i_req.smm && i_req.code && !i_req.write) ?
						SMMRC_TO_DRAM : vga_dest;
				end
				`SMMRC_LOWER_SECURE_RANGE_SELECT_SMM: begin
					o_resp.dest = i_req.smm ? SMMRC_TO_DRAM : vga_dest;
				end
				default: begin
					o_resp.dest = vga_dest;
				end
			endcase
		end else if (in_high_secure_remap) begin
			if (i_req.smm) begin
				o_resp.dest = SMMRC_TO_DRAM;
				o_resp.addr = `SMMRC_AB_BASE |
					(i_req.addr & `SMMRC_AB_OFS_MASK);
			end else begin
				o_resp.dest = SMMRC_TO_HUB;
				o_resp.violation = i_req.valid && !i_req.writeback;
			end
		end else if (in_top_secure_segment) begin
			if (i_req.smm) begin
				o_resp.dest = SMMRC_TO_DRAM;
			end else begin
				o_resp.dest = SMMRC_TO_HUB;
				o_resp.violation = i_req.valid && !i_req.writeback;
			end
		end else if (in_gfx) begin
			o_resp.dest = SMMRC_TO_HUB;
		end else if (in_ram) begin
			o_resp.dest = SMMRC_TO_DRAM;
		end else begin
			o_resp.dest = SMMRC_TO_HUB;
		end
	end

endmodule

// [tb/smmrc_props.sv]
// assertions on the ports of the smm range control block
`timescale 1ns/1ps
module smmrc_props (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// configuration access
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	input wire logic [7:0] o_cfg_rdata,
	// memory request side
	input wire logic [31:0] i_tom,
	input wire smmrc_pkg::smmrc_req_t i_req,
	input wire smmrc_pkg::smmrc_resp_t o_resp,
	// status
	input wire logic o_gfx_enable,
	input wire logic o_gfx_clk_en,
	input wire logic o_dram_param_lock,
	input wire logic o_violation,
	input wire logic [31:0] o_top_secure_segment_base,
	input wire logic [31:0] o_gfx_base,
	input wire logic [31:0] o_sysram_top
);
	import smmrc_pkg::*;
	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic clr1;
	assign clr1 = i_cfg_wr && i_cfg_addr == 8'h70 && i_cfg_wdata[0];
	chk_clk_gate:
		assert property (o_gfx_clk_en == o_gfx_enable)
		else $error("graphics clock gate differs from enable");
	chk_lock_hold:
		assert property (o_dram_param_lock |=> o_dram_param_lock)
		else $error("lock cleared without reset");
	chk_resp_next:
		assert property (i_req.valid |=> o_resp.valid)
		else $error("no answer one cycle after request");
	chk_flag_set:
		assert property (o_resp.violation |-> o_violation)
		else $error("violation did not set flag");
	chk_viol_hub:
		assert property (o_resp.violation |-> o_resp.dest == SMMRC_TO_HUB)
		else $error("violating access not sent to hub");
	chk_flag_hold:
		assert property (o_violation && !clr1 |=> o_violation)
		else $error("flag dropped without write of one");
	chk_wb_quiet:
		assert property (i_req.valid && i_req.writeback |=> !o_resp.violation)
		else $error("write-back flagged as violation");
	chk_top_secure_segment_smm:
		assert property (i_req.valid && i_req.smm && !i_cfg_wr
			&& i_req.addr >= o_top_secure_segment_base && i_req.addr < i_tom
			|=> o_resp.dest == SMMRC_TO_DRAM)
		else $error("smm top segment access not to dram");
	chk_gfx_carve:
		assert property (o_gfx_base <= o_top_secure_segment_base && o_top_secure_segment_base <= i_tom)
		else $error("carve order wrong");
	chk_sysram_top:
		assert property (o_sysram_top == o_gfx_base)
		else $error("system ram overlaps taken memory");
	cover property (o_resp.violation);
	cover property (o_resp.valid && o_resp.dest == SMMRC_TO_GFX);
	cover property (o_dram_param_lock && i_cfg_wr);
endmodule

// [tb/smmrc_cpu_model.sv]
// processor side model issuing single memory requests
`timescale 1ns/1ps
module smmrc_cpu_model (
	// clock
	input wire logic i_clk,
	// request out
	output smmrc_pkg::smmrc_req_t o_req
);
	import smmrc_pkg::*;
	initial o_req = '0;
	// f = smm, code, write, writeback; one cycle per request
	task automatic issue(input logic [31:0] a, input logic [3:0] f);
		@(posedge i_clk);
		#1;
		o_req = {1'b1, a, f};
		@(posedge i_clk);
		#1;
		o_req = {1'b0, ~a, ~f};
	endtask
endmodule

// [tb/test_smmrc_ctrl.sv]
// self-checking bench for the smm range control block
`timescale 1ns/1ps
`include "smmrc_map.svh"
module test_smmrc_ctrl;
	import smmrc_pkg::*;
	localparam logic [31:0] TOP_OF_MEMORY = 32'h0400_0000;
	localparam logic [31:0] AB = `SMMRC_AB_BASE;
	localparam logic [31:0] TB = TOP_OF_MEMORY - `SMMRC_SIZE_512K;
	localparam logic [31:0] GB = TB - `SMMRC_SIZE_1M;
	localparam logic [1:0] D = SMMRC_TO_DRAM;
	localparam logic [1:0] G = SMMRC_TO_GFX;
	localparam logic [1:0] H = SMMRC_TO_HUB;
	logic i_clk, i_rstn, i_cfg_wr, i_cfg_rd;
	logic [7:0] i_cfg_addr, i_cfg_wdata, o_cfg_rdata;
	logic [31:0] i_tom, o_top_secure_segment_base, o_gfx_base, o_sysram_top;
	logic o_gfx_enable, o_gfx_clk_en, o_dram_param_lock, o_violation;
	smmrc_req_t i_req;
	smmrc_resp_t o_resp;
	int num_errors = 0;
	int cmp_count = 0;
	smmrc_ctrl dut_u (.i_clk, .i_rstn, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
		.i_cfg_wdata, .o_cfg_rdata, .i_tom, .i_req, .o_resp, .o_gfx_enable,
		.o_gfx_clk_en, .o_dram_param_lock, .o_violation, .o_top_secure_segment_base,
		.o_gfx_base, .o_sysram_top);
	smmrc_cpu_model cpu_u (.i_clk, .o_req(i_req));
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] s, e, input string m);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_clk);
		#1;
		i_cfg_wr = 1'b1;
		i_cfg_addr = a;
		i_cfg_wdata = d;
		@(posedge i_clk);
		#1;
		i_cfg_wr = 1'b0;
		i_cfg_addr = ~a;
		i_cfg_wdata = ~d;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] e);
		@(posedge i_clk);
		#1;
		i_cfg_rd = 1'b1;
		i_cfg_addr = 8'h70;
		@(posedge i_clk);
		#1;
		i_cfg_rd = 1'b0;
		i_cfg_addr = 8'h8F;
		check(o_cfg_rdata, e, "register read");
	endtask
	task automatic req(input logic [31:0] a, input logic [3:0] f,
		input logic [1:0] d, input logic v);
		cpu_u.issue(a, f);
		check(o_resp.valid, 1'b1, "no answer");
		check(o_resp.dest, d, "route");
		check(o_resp.violation, v, "violation");
	endtask
	task automatic do_reset();
		i_rstn = 1'b0;
		repeat (20) @(posedge i_clk);
		#1;
		i_rstn = 1'b1;
	endtask
	task automatic conclude();
		if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		rd(8'h00);
		check(o_sysram_top, TOP_OF_MEMORY, "reset map");
		wr(8'h71, 8'hA0);
		rd(8'h00);
	endtask
	task automatic t_gfx();
		for (int g = 0; g < 4; g++) begin
			wr(8'h70, {g[1:0], 6'h00});
			check(o_gfx_enable, g != 0, "gfx enable");
			check(o_gfx_clk_en, g != 0, "gfx clock");
			check(o_gfx_base, TOP_OF_MEMORY - (g[1] ? `SMMRC_SIZE_512K << g[0] : 0),
				"gfx size");
			if (g != 1) req(AB, 4'h0, g ? G : H, 1'b0);
		end
	endtask
	task automatic t_lower();
		for (int l = 0; l < 4; l++) begin
			wr(8'h70, {4'h8, l[1:0], 2'h0});
			req(AB + 16, 4'hC, l ? D : G, 1'b0);
			req(AB, 4'h8, l[0] ? D : G, 1'b0);
			req(AB, 4'hE, l[0] ? D : G, 1'b0);
			req(AB, 4'h0, l == 1 ? D : G, 1'b0);
		end
	endtask
	task automatic t_top_secure_segment();
		wr(8'h70, 8'h00);
		req(TB, 4'hA, D, 1'b0);
		wr(8'h70, 8'hE0);
		check(o_top_secure_segment_base, TB, "top segment base");
		check(o_gfx_base, GB, "graphics base");
		req(TB, 4'h8, D, 1'b0);
		req(TOP_OF_MEMORY - 1, 4'hC, D, 1'b0);
		req(TB, 4'h3, H, 1'b0);
		check(o_violation, 1'b0, "write-back flag");
		req(TB + 4, 4'h0, H, 1'b1);
		check(o_violation, 1'b1, "flag set");
		req(GB, 4'h8, H, 1'b0);
		req(GB - 4, 4'h0, D, 1'b0);
		wr(8'h70, 8'hE0);
		rd(8'hE1);
		wr(8'h70, 8'hE1);
		rd(8'hE0);
	endtask
	task automatic t_high_secure_remap();
		wr(8'h70, 8'h10);
		req(`SMMRC_HIGH_SECURE_REMAP_BASE + 16, 4'h8, D, 1'b0);
		check(o_resp.addr, AB + 16, "remap address");
		req(`SMMRC_HIGH_SECURE_REMAP_LAST, 4'h0, H, 1'b1);
		wr(8'h70, 8'h15);
		req(`SMMRC_HIGH_SECURE_REMAP_BASE, 4'h8, H, 1'b0);
	endtask
	task automatic t_lock();
		wr(8'h70, 8'hBE);
		check(o_dram_param_lock, 1'b1, "dram lock");
		wr(8'h70, 8'h40);
		rd(8'hBA);
		wr(8'h70, 8'h04);
		rd(8'hBE);
		do_reset();
		rd(8'h00);
		wr(8'h70, 8'h02);
		wr(8'h70, 8'h0C);
		rd(8'h02);
		do_reset();
	endtask
	// ------------------------------------------------------------------
	// run
	// ------------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	initial begin
		#300000;
		num_errors++;
		conclude();
	end
	initial begin
		i_cfg_wr = 1'b0;
		i_cfg_rd = 1'b0;
		i_cfg_addr = 8'h00;
		i_cfg_wdata = 8'h00;
		i_tom = TOP_OF_MEMORY;
		do_reset();
		t_regs();
		t_gfx();
		t_lower();
		t_top_secure_segment();
		t_high_secure_remap();
		t_lock();
		conclude();
	end
endmodule
bind smmrc_ctrl smmrc_props chk_u (.i_clk, .i_rstn, .i_cfg_wr, .i_cfg_rd,
	.i_cfg_addr, .i_cfg_wdata, .o_cfg_rdata, .i_tom, .i_req, .o_resp,
	.o_gfx_enable, .o_gfx_clk_en, .o_dram_param_lock, .o_violation,
	.o_top_secure_segment_base, .o_gfx_base, .o_sysram_top);
